// >>> core/iss_pkg.sv
package iss_pkg;
    // Register offsets on the two-wire port.
    localparam logic [7:0] OFS_MODE2 = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h11;
    localparam logic [7:0] OFS_OVERRIDE = 8'h12;
    // Reset values and writable bits; the two low mode bits are not held.
    localparam logic [7:0] MODE2_RST = 8'h34;
    localparam logic [7:0] OVR_RST = 8'h01;
    localparam logic [7:0] MODE2_WMASK = 8'hFC;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    // Serial address of the port; the value is arbitrary.
    localparam logic [6:0] DEV_ADDR_DEF = 7'h4C;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [2:0] BIT_FIRST = 3'h0;
    localparam logic [7:0] PTR_STEP = 8'h01;
    // Activity window of the detectors.
    localparam int CLK_PERIOD_NS = 4;
    localparam int DET_WINDOW_NS = 100000;
    localparam int DET_WINDOW_CYC = DET_WINDOW_NS / CLK_PERIOD_NS;
    // Drive field codes.
    localparam logic [1:0] DRV_CODE_LOW = 2'h0;
    localparam logic [1:0] DRV_CODE_MED = 2'h1;

    typedef enum logic [1:0] {
        ISS_DRV_LOW = 2'h0,
        ISS_DRV_MED = 2'h1,
        ISS_DRV_HIGH = 2'h2
    } iss_drive_e;

    typedef struct packed {
        logic clk_invert;
        logic two_pix;
        logic [1:0] drive;
        logic output_float;
        logic sync_pol;
        logic [1:0] unused;
    } iss_mode2_s;

    typedef struct packed {
        logic port_override;
        logic port_choose;
        logic hs_override;
        logic hs_choose;
        logic vs_override;
        logic vs_choose;
        logic coast_vsync;
        logic chip_sleep_n;
    } iss_ovr_s;

    typedef struct packed {
        logic hs;
        logic sog;
        logic vs;
        logic clk;
    } iss_det_s;

    typedef enum logic [8:0] {
        ISS_IDLE = 9'h001,
        ISS_ADDR = 9'h002,
        ISS_ADDR_ACK = 9'h004,
        ISS_PTR = 9'h008,
        ISS_PTR_ACK = 9'h010,
        ISS_WDATA = 9'h020,
        ISS_WDATA_ACK = 9'h040,
        ISS_RDATA = 9'h080,
        ISS_RDATA_ACK = 9'h100
    } iss_state_e;
endpackage

// >>> core/iss_activity_det.sv
`timescale 1ns/10ps
module iss_activity_det #(
    parameter int TIMEOUT_CYC = iss_pkg::DET_WINDOW_CYC
) (
    input wire logic mclk_in,
    input wire logic rst_b_in,
    input wire logic sig_in,
    output logic present_out
);
    localparam int CW = $clog2(TIMEOUT_CYC + 1);
    localparam logic [CW-1:0] CNT_LAST = CW'(TIMEOUT_CYC - 1);
    localparam logic [CW-1:0] CNT_ZERO = CW'(0);
    localparam logic [CW-1:0] CNT_ONE = CW'(1);

    logic sig_reg, sig_next;
    logic present_reg, present_next;
    logic [CW-1:0] cnt_reg, cnt_next;

    // Any edge restarts the window; a quiet window means the source is gone.
    always_comb begin
        sig_next = sig_in;
        present_next = present_reg;
        cnt_next = cnt_reg;
        if (sig_in != sig_reg) begin
            present_next = 1'b1;
            cnt_next = CNT_ZERO;
        end else if (cnt_reg == CNT_LAST) begin
            present_next = 1'b0;
        end else begin
            cnt_next = cnt_reg + CNT_ONE;
        end
    end

    // Registers only; the sampled level follows the pin during reset so that
    // an input resting high does not look like an edge once reset is released.
    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            sig_reg <= sig_next;
            present_reg <= 1'b0;
            cnt_reg <= CNT_ZERO;
        end else begin
            sig_reg <= sig_next;
            present_reg <= present_next;
            cnt_reg <= cnt_next;
        end
    end

    assign present_out = present_reg;
endmodule // iss_activity_det

// >>> core/iss_regs.sv
`timescale 1ns/10ps
module iss_regs #(
    parameter logic [6:0] DEV_ADDR = iss_pkg::DEV_ADDR_DEF,
    parameter int DET_TIMEOUT_CYC = iss_pkg::DET_WINDOW_CYC
) (
    input wire logic mclk_in,
    input wire logic rst_b_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    input wire logic hsync_pin_in,
    input wire logic sog_sync_in,
    input wire logic raw_vsync_in,
    input wire logic sep_vsync_in,
    input wire logic dig_clk_in,
    input wire logic coast_pin_in,
    output logic hsync_out,
    output logic vsync_out,
    output logic coast_out,
    output logic two_pix_per_clk_out,
    output logic clk_invert_out,
    output iss_pkg::iss_drive_e drive_strength_out,
    output logic data_oe_out,
    output logic sync_present_pin_out,
    output logic digital_active_out,
    output logic chip_sleep_n_out
);
    iss_pkg::iss_det_s det;
    iss_pkg::iss_state_e st_reg, st_next;
    logic [2:0] cnt_reg, cnt_next;
    logic [7:0] sh_reg, sh_next;
    logic [7:0] ptr_reg, ptr_next;
    logic rdy_reg, rdy_next;
    logic rw_reg, rw_next;
    logic oe_reg, oe_next;
    logic scl_q_reg, sda_q_reg;
    logic scl_rise, scl_fall, bus_start, bus_stop;
    logic wr_en, load;
    logic [7:0] wr_data, rd_data;
    iss_pkg::iss_mode2_s mode2_reg, mode2_next;
    iss_pkg::iss_ovr_s ovr_reg, ovr_next;
    logic [7:0] status_reg, status_next;
    logic analog_seen, auto_port, active_port, auto_h, active_h, active_v, sync_seen;
    logic vsync_sel;
    logic hsync_reg, vsync_reg, coast_reg, two_pix_reg, data_oe_reg, sync_present_pin_reg, port_reg;
    logic hsync_next, vsync_next, coast_next, two_pix_next, data_oe_next, sync_present_pin_next, port_next;
    iss_pkg::iss_drive_e drive_reg, drive_next;

    function automatic logic reg_hit(input logic [7:0] p, input logic [7:0] ofs);
        return p == ofs;
    endfunction

    // One detector per watched source.
    localparam int NDET = 4;
    logic [NDET-1:0] det_src, det_vec;
    assign det_src = {hsync_pin_in, sog_sync_in, raw_vsync_in, dig_clk_in};
    genvar gi;
    generate
        for (gi = 0; gi < NDET; gi++) begin : g_det
            iss_activity_det #(.TIMEOUT_CYC(DET_TIMEOUT_CYC)) u_det (
                .mclk_in(mclk_in),
                .rst_b_in(rst_b_in),
                .sig_in(det_src[gi]),
                .present_out(det_vec[gi])
            );
        end
    endgenerate
    assign det = iss_pkg::iss_det_s'(det_vec);

    // Bus conditions seen against the previous sample of both lines.
    assign scl_rise = scl_in && !scl_q_reg;
    assign scl_fall = !scl_in && scl_q_reg;
    assign bus_start = scl_in && scl_q_reg && sda_q_reg && !sda_in;
    assign bus_stop = scl_in && scl_q_reg && !sda_q_reg && sda_in;

    // Read multiplexer; unmapped offsets read as zero.
    always_comb begin
        rd_data = iss_pkg::BYTE_ZERO;
        if (reg_hit(ptr_reg, iss_pkg::OFS_MODE2)) begin
            rd_data = mode2_reg & iss_pkg::MODE2_WMASK;
        end else if (reg_hit(ptr_reg, iss_pkg::OFS_STATUS)) begin
            rd_data = status_reg;
        end else if (reg_hit(ptr_reg, iss_pkg::OFS_OVERRIDE)) begin
            rd_data = ovr_reg;
        end
    end

    // Serial slave: address, pointer, then data bytes with auto increment.
    // Data changes on falling clock edges and is sampled on rising ones.
    always_comb begin
        st_next = st_reg;
        cnt_next = cnt_reg;
        sh_next = sh_reg;
        ptr_next = ptr_reg;
        rdy_next = rdy_reg;
        rw_next = rw_reg;
        oe_next = oe_reg;
        wr_en = 1'b0;
        wr_data = sh_reg;
        load = 1'b0;
        if (bus_stop) begin
            st_next = iss_pkg::ISS_IDLE;
            oe_next = 1'b0;
        end else if (bus_start) begin
            st_next = iss_pkg::ISS_ADDR;
            cnt_next = iss_pkg::BIT_FIRST;
            rdy_next = 1'b0;
            oe_next = 1'b0;
        end else begin
            case (st_reg)
                iss_pkg::ISS_ADDR, iss_pkg::ISS_PTR, iss_pkg::ISS_WDATA: begin
                    if (scl_rise) begin
                        sh_next = {sh_reg[6:0], sda_in};
                        cnt_next = cnt_reg + 3'h1;
                        rdy_next = (cnt_reg == iss_pkg::BIT_LAST);
                    end else if (scl_fall && rdy_reg) begin
                        rdy_next = 1'b0;
                        oe_next = 1'b1;
                        if (st_reg == iss_pkg::ISS_ADDR) begin
                            if (sh_reg[7:1] == DEV_ADDR) begin
                                st_next = iss_pkg::ISS_ADDR_ACK;
                                rw_next = sh_reg[0];
                            end else begin
                                st_next = iss_pkg::ISS_IDLE;
                                oe_next = 1'b0;
                            end
                        end else if (st_reg == iss_pkg::ISS_PTR) begin
                            ptr_next = sh_reg;
                            st_next = iss_pkg::ISS_PTR_ACK;
                        end else begin
                            wr_en = 1'b1;
                            ptr_next = ptr_reg + iss_pkg::PTR_STEP;
                            st_next = iss_pkg::ISS_WDATA_ACK;
                        end
                    end
                end
                iss_pkg::ISS_ADDR_ACK, iss_pkg::ISS_PTR_ACK, iss_pkg::ISS_WDATA_ACK: begin
                    if (scl_fall) begin
                        oe_next = 1'b0;
                        cnt_next = iss_pkg::BIT_FIRST;
                        if (st_reg == iss_pkg::ISS_ADDR_ACK && rw_reg) begin
                            load = 1'b1;
                        end else if (st_reg == iss_pkg::ISS_ADDR_ACK) begin
                            st_next = iss_pkg::ISS_PTR;
                        end else begin
                            st_next = iss_pkg::ISS_WDATA;
                        end
                    end
                end
                iss_pkg::ISS_RDATA: begin
                    if (scl_fall) begin
                        if (cnt_reg == iss_pkg::BIT_LAST) begin
                            oe_next = 1'b0;
                            rdy_next = 1'b0;
                            st_next = iss_pkg::ISS_RDATA_ACK;
                        end else begin
                            sh_next = {sh_reg[6:0], 1'b0};
                            oe_next = !sh_reg[6];
                            cnt_next = cnt_reg + 3'h1;
                        end
                    end
                end
                iss_pkg::ISS_RDATA_ACK: begin
                    // A high line on the acknowledge bit ends the read.
                    if (scl_rise) begin
                        rdy_next = sda_in;
                    end else if (scl_fall && rdy_reg) begin
                        st_next = iss_pkg::ISS_IDLE;
                        rdy_next = 1'b0;
                    end else if (scl_fall) begin
                        load = 1'b1;
                        cnt_next = iss_pkg::BIT_FIRST;
                    end
                end
                default: begin
                    st_next = iss_pkg::ISS_IDLE;
                end
            endcase
        end
        if (load) begin
            sh_next = rd_data;
            ptr_next = ptr_reg + iss_pkg::PTR_STEP;
            oe_next = !rd_data[7];
            st_next = iss_pkg::ISS_RDATA;
        end
    end

    // Registers of the serial slave.
    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            st_reg <= iss_pkg::ISS_IDLE;
            cnt_reg <= iss_pkg::BIT_FIRST;
            sh_reg <= iss_pkg::BYTE_ZERO;
            ptr_reg <= iss_pkg::BYTE_ZERO;
            rdy_reg <= 1'b0;
            rw_reg <= 1'b0;
            oe_reg <= 1'b0;
            scl_q_reg <= 1'b1;
            sda_q_reg <= 1'b1;
        end else begin
            st_reg <= st_next;
            cnt_reg <= cnt_next;
            sh_reg <= sh_next;
            ptr_reg <= ptr_next;
            rdy_reg <= rdy_next;
            rw_reg <= rw_next;
            oe_reg <= oe_next;
            scl_q_reg <= scl_in;
            sda_q_reg <= sda_in;
        end
    end

    // Register writes; the status offset has no storage to write.
    always_comb begin
        mode2_next = mode2_reg;
        ovr_next = ovr_reg;
        if (wr_en && reg_hit(ptr_reg, iss_pkg::OFS_MODE2)) begin
            mode2_next = iss_pkg::iss_mode2_s'(wr_data & iss_pkg::MODE2_WMASK);
        end else if (wr_en && reg_hit(ptr_reg, iss_pkg::OFS_OVERRIDE)) begin
            ovr_next = iss_pkg::iss_ovr_s'(wr_data);
        end
    end

    // Source selection; overrides win, otherwise what is detected decides, with the choose bit deciding when both port or both horizontal sources are seen.
    always_comb begin
        analog_seen = det.hs || det.sog;
        auto_port = (analog_seen && det.clk) ? ovr_reg.port_choose : det.clk;
        active_port = ovr_reg.port_override ? ovr_reg.port_choose : auto_port;
        auto_h = (det.hs && det.sog) ? ovr_reg.hs_choose : (det.sog && !det.hs);
        active_h = ovr_reg.hs_override ? ovr_reg.hs_choose : auto_h;
        // Without raw vertical sync only the separator can supply one.
        active_v = ovr_reg.vs_override ? ovr_reg.vs_choose : !det.vs;
        sync_seen = active_port ? det.clk : analog_seen;
        vsync_sel = active_v ? sep_vsync_in : raw_vsync_in;
        hsync_next = active_h ? sog_sync_in : hsync_pin_in;
        vsync_next = vsync_sel;
        coast_next = ovr_reg.coast_vsync ? vsync_sel : coast_pin_in;
        two_pix_next = mode2_reg.two_pix && active_port;
        data_oe_next = !mode2_reg.output_float;
        sync_present_pin_next = (sync_seen == mode2_reg.sync_pol);
        port_next = active_port;
        status_next = {det, active_port, active_h, active_v, 1'b0};
        if (mode2_reg.drive == iss_pkg::DRV_CODE_LOW) begin
            drive_next = iss_pkg::ISS_DRV_LOW;
        end else if (mode2_reg.drive == iss_pkg::DRV_CODE_MED) begin
            drive_next = iss_pkg::ISS_DRV_MED;
        end else begin
            drive_next = iss_pkg::ISS_DRV_HIGH;
        end
    end

    // Control registers, status and every output but the serial data line.
    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            mode2_reg <= iss_pkg::iss_mode2_s'(iss_pkg::MODE2_RST);
            ovr_reg <= iss_pkg::iss_ovr_s'(iss_pkg::OVR_RST);
            status_reg <= iss_pkg::BYTE_ZERO;
            drive_reg <= iss_pkg::ISS_DRV_HIGH;
            hsync_reg <= 1'b0;
            vsync_reg <= 1'b0;
            coast_reg <= 1'b0;
            two_pix_reg <= 1'b0;
            data_oe_reg <= 1'b0;
            sync_present_pin_reg <= 1'b0;
            port_reg <= 1'b0;
        end else begin
            mode2_reg <= mode2_next;
            ovr_reg <= ovr_next;
            status_reg <= status_next;
            drive_reg <= drive_next;
            hsync_reg <= hsync_next;
            vsync_reg <= vsync_next;
            coast_reg <= coast_next;
            two_pix_reg <= two_pix_next;
            data_oe_reg <= data_oe_next;
            sync_present_pin_reg <= sync_present_pin_next;
            port_reg <= port_next;
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe_out = oe_reg;
    assign hsync_out = hsync_reg;
    assign vsync_out = vsync_reg;
    assign coast_out = coast_reg;
    assign two_pix_per_clk_out = two_pix_reg;
    assign clk_invert_out = mode2_reg.clk_invert;
    assign drive_strength_out = drive_reg;
    assign data_oe_out = data_oe_reg;
    assign sync_present_pin_out = sync_present_pin_reg;
    assign digital_active_out = port_reg;
    assign chip_sleep_n_out = ovr_reg.chip_sleep_n;

    // Checks on the control behaviour.
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_b_in);

    sequence s_ovr_write;
        wr_en && reg_hit(ptr_reg, iss_pkg::OFS_OVERRIDE);
    endsequence
    property p_pix;
        !digital_active_out |-> !two_pix_per_clk_out;
    endproperty
    a_pix: assert property (p_pix) else $error("two pixel mode on analog port");
    property p_drive;
        (mode2_reg.drive == iss_pkg::DRV_CODE_MED)
            |=> (drive_strength_out == iss_pkg::ISS_DRV_MED);
    endproperty
    a_drive: assert property (p_drive) else $error("drive code 01 not medium");
    property p_float;
        mode2_reg.output_float |=> !data_oe_out;
    endproperty
    a_float: assert property (p_float) else $error("outputs driven while floated");
    property p_sync_present_pin;
        ##1 sync_present_pin_out == ($past(sync_seen) == $past(mode2_reg.sync_pol));
    endproperty
    a_sync_present_pin: assert property (p_sync_present_pin) else $error("sync present pin polarity wrong");
    property p_stat_hs;
        ##1 status_reg[7] == $past(det.hs);
    endproperty
    a_stat_hs: assert property (p_stat_hs) else $error("hsync detect bit stale");
    property p_port_ovr;
        ovr_reg.port_override |=> digital_active_out == $past(ovr_reg.port_choose);
    endproperty
    a_port_ovr: assert property (p_port_ovr) else $error("port override ignored");
    property p_port_auto;
        (!ovr_reg.port_override && det.clk && !det.hs && !det.sog) |=> digital_active_out;
    endproperty
    a_port_auto: assert property (p_port_auto) else $error("digital only not chosen");
    property p_hs_ovr;
        ovr_reg.hs_override |=> status_reg[2] == $past(ovr_reg.hs_choose);
    endproperty
    a_hs_ovr: assert property (p_hs_ovr) else $error("hsync override ignored");
    property p_sleep;
        s_ovr_write ##0 !wr_data[0] |=> !chip_sleep_n_out ##1 !chip_sleep_n_out[*2];
    endproperty
    a_sleep: assert property (p_sleep) else $error("power down write lost");
    property p_wake;
        s_ovr_write ##0 wr_data[0] |=> chip_sleep_n_out;
    endproperty
    a_wake: assert property (p_wake) else $error("wake write lost");
endmodule // iss_regs

// >>> test/iss_host_model.sv
`timescale 1ns/10ps
module iss_host_model (
    input wire logic mclk_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_low_out
);
    // The serial clock rests driven high and the data line released, so its pull-up holds it high.
    initial begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
    end

    // Every serial phase lasts several system cycles so the device never misses an edge.
    task automatic pause(input int n);
        repeat (n) @(negedge mclk_in);
    endtask

    // Start or repeated start: data falls while the serial clock is high.
    task automatic start();
        sda_low_out = 1'b0;
        pause(2);
        scl_out = 1'b1;
        pause(4);
        sda_low_out = 1'b1;
        pause(4);
        scl_out = 1'b0;
        pause(2);
    endtask

    // Stop: data rises while the serial clock is high.
    task automatic stop();
        sda_low_out = 1'b1;
        pause(2);
        scl_out = 1'b1;
        pause(4);
        sda_low_out = 1'b0;
        pause(4);
    endtask

    // Data moves only in the low phase, and the line is read late in the high phase.
    task automatic bit_slot(input logic drv, output logic seen);
        sda_low_out = !drv;
        pause(2);
        scl_out = 1'b1;
        pause(4);
        seen = sda_in;
        scl_out = 1'b0;
        pause(2);
    endtask

    // Eight bits, most significant first, then the acknowledge slot.
    task automatic xfer(input logic [7:0] tx, input logic ack_drv,
                        output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_slot(tx[i], rx[i]);
        end
        bit_slot(ack_drv, ack);
    endtask
endmodule // iss_host_model

// >>> test/testbench.sv
`timescale 1ns/10ps
module testbench;
    localparam int DET_CYC = 20;
    localparam logic [7:0] ADDR_W = {iss_pkg::DEV_ADDR_DEF, 1'b0};
    logic mclk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic [5:0] vid_en = 6'h00;
    logic [5:0] vid = 6'h2A;
    logic scl, host_low, sda_drv, sda_oe, sda_wire;
    logic hs_o, vs_o, coast_o, two_pix, clk_inv, oe_o, syncp, dig_act, sleep_n;
    iss_pkg::iss_drive_e drive;
    int fails = 0;
    int cmp_count = 0;
    int cyc = 0;

    // Open-drain data line with a pull-up.
    assign sda_wire = host_low ? 1'b0 : (sda_oe ? sda_drv : 1'b1);

    always #2 mclk_in = ~mclk_in;

    iss_host_model host (.mclk_in(mclk_in), .sda_in(sda_wire), .scl_out(scl),
        .sda_low_out(host_low));

    iss_regs #(.DET_TIMEOUT_CYC(DET_CYC)) dut (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
        .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_drv), .sda_oe_out(sda_oe),
        .hsync_pin_in(vid[0]), .sog_sync_in(vid[1]), .raw_vsync_in(vid[2]),
        .sep_vsync_in(vid[3]), .dig_clk_in(vid[4]), .coast_pin_in(vid[5]),
        .hsync_out(hs_o), .vsync_out(vs_o), .coast_out(coast_o),
        .two_pix_per_clk_out(two_pix), .clk_invert_out(clk_inv),
        .drive_strength_out(drive), .data_oe_out(oe_o),
        .sync_present_pin_out(syncp), .digital_active_out(dig_act),
        .chip_sleep_n_out(sleep_n));

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic summarize();
        if (fails == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Enabled video inputs toggle every eight cycles, well inside the detector window.
    always @(negedge mclk_in) begin
        cyc <= cyc + 1;
        if (cyc % 8 == 0) begin
            vid <= vid ^ vid_en;
        end
        if (cyc == 40000) begin
            fails++;
            summarize();
        end
    end

    // Selected port, horizontal source and vertical source, in that order.
    function automatic logic [2:0] sel(input logic [5:0] en, input logic [7:0] ovr);
        sel[2] = (ovr[7] | ((en[0] | en[1]) & en[4])) ? ovr[6] : en[4];
        sel[1] = (ovr[5] | (en[0] & en[1])) ? ovr[4] : en[1];
        sel[0] = ovr[3] ? ovr[2] : !en[2];
    endfunction

    task automatic wr(input logic [7:0] ptr, input logic [7:0] data);
        logic [7:0] rx;
        logic ack;
        host.start();
        host.xfer(ADDR_W, 1'b1, rx, ack);
        check("address ack", {7'h00, ack}, 8'h00);
        host.xfer(ptr, 1'b1, rx, ack);
        host.xfer(data, 1'b1, rx, ack);
        host.stop();
    endtask

    // Reads two bytes in one transfer, so the pointer must step between them.
    task automatic rd(input logic [7:0] ptr, output logic [7:0] b0, output logic [7:0] b1);
        logic ack;
        host.start();
        host.xfer(ADDR_W, 1'b1, b0, ack);
        host.xfer(ptr, 1'b1, b0, ack);
        host.start();
        host.xfer(ADDR_W | 8'h01, 1'b1, b0, ack);
        host.xfer(8'hFF, 1'b0, b0, ack);
        host.xfer(8'hFF, 1'b1, b1, ack);
        host.stop();
    endtask

    initial begin
        logic [7:0] mode, ovr, rb0, rb1;
        logic [2:0] s;
        logic ack;
        void'($urandom(32'hF71FF108));
        repeat (10) @(negedge mclk_in);
        rst_b_in = 1'b1;
        @(negedge mclk_in);
        rd(8'h10, rb0, rb1);
        check("mode reset", rb0, iss_pkg::MODE2_RST);
        rd(8'h12, rb0, rb1);
        check("override reset", rb0, iss_pkg::OVR_RST);
        check("unmapped read", rb1, 8'h00);
        // A foreign address must be left unanswered.
        host.start();
        host.xfer({iss_pkg::DEV_ADDR_DEF ^ 7'h01, 1'b0}, 1'b1, rb0, ack);
        host.stop();
        check("foreign ack", {7'h00, ack}, 8'h01);
        for (int i = 0; i < 16; i++) begin
            mode = 8'($urandom());
            mode[5:4] = i[2:1];
            ovr = 8'($urandom()) & (i[0] ? 8'hFF : 8'h57);
            ovr[0] = i[1];
            vid_en = (i == 0) ? 6'h3F : (i == 2) ? 6'h00 : 6'($urandom());
            wr(8'h10, mode);
            wr(8'h12, ovr);
            wr(8'h11, 8'($urandom()));
            repeat (3 * DET_CYC) @(negedge mclk_in);
            while (cyc % 8 != 4) @(posedge mclk_in);
            #1;
            s = sel(vid_en, ovr);
            check("port", {7'h00, dig_act}, {7'h00, s[2]});
            check("hsync", {7'h00, hs_o}, {7'h00, s[1] ? vid[1] : vid[0]});
            check("vsync", {7'h00, vs_o}, {7'h00, s[0] ? vid[3] : vid[2]});
            check("coast", {7'h00, coast_o},
                {7'h00, ovr[1] ? (s[0] ? vid[3] : vid[2]) : vid[5]});
            check("pixels", {7'h00, two_pix}, {7'h00, mode[6] & s[2]});
            check("drive", {6'h00, drive}, {6'h00, mode[5] ? 2'h2 : mode[5:4]});
            check("data drive", {7'h00, oe_o}, {7'h00, !mode[3]});
            check("sync pin", {7'h00, syncp}, {7'h00,
                !((s[2] ? vid_en[4] : |vid_en[1:0]) ^ mode[2])});
            check("sleep", {7'h00, sleep_n}, {7'h00, ovr[0]});
            check("clock invert", {7'h00, clk_inv}, {7'h00, mode[7]});
            rd(8'h10, rb0, rb1);
            check("mode", rb0, mode & iss_pkg::MODE2_WMASK);
            check("status", rb1 & (i[0] ? 8'hF0 : 8'hFF),
                {vid_en[0], vid_en[1], vid_en[2], vid_en[4], sel(vid_en, ovr & 8'h57), 1'b0}
                & (i[0] ? 8'hF0 : 8'hFF));
            rd(8'h12, rb0, rb1);
            check("override", rb0, ovr);
        end
        summarize();
    end
endmodule // testbench
